// ==== hdl/rst_seq_params.svh ====
// Purpose: constants for the reset output and soft reset sequencer
// Assumes: 250 MHz system clock
// Notes:   times in microseconds, cycle counts derived from them
`ifndef RST_SEQ_PARAMS_SVH
`define RST_SEQ_PARAMS_SVH

`define CLK_MHZ                 250
`define RESET_FILTER_TIME_US    10
`define EXTENDED_DELAY_US       10
`define REDUCED_DELAY_US        2
`define FILTER_CYCLES           (`RESET_FILTER_TIME_US * `CLK_MHZ)
`define EXTENDED_DELAY_CYCLES   (`EXTENDED_DELAY_US * `CLK_MHZ)
`define REDUCED_DELAY_CYCLES    (`REDUCED_DELAY_US * `CLK_MHZ)

// register byte offsets
`define REG_MODE_CTRL           32'h0000_0000
`define REG_RESET_CTRL          32'h0000_0004
`define REG_STATUS              32'h0000_0008

// mode control fields
`define MODE_LSB                0
`define MODE_SOFT_RESET         2'h3
`define MODE_RESET_VALUE        2'h0
// reset control fields
`define DELAY_SEL_BIT           0
`define SOFT_RST_OUT_SEL_BIT    1
`define THRESH_LSB              2
`define THRESH_RESET_VALUE      2'h0

`endif

// ==== hdl/rst_seq_pkg.sv ====
// Purpose: types shared by the reset sequencer files
// Assumes: nothing
// Notes:   constants live in rst_seq_params.svh
package rst_seq_pkg;

    typedef enum logic [1:0] {
        MODE_INIT,
        MODE_NORMAL,
        MODE_STOP,
        MODE_OTHER
    } dev_mode_t;

    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic        we;
        logic        cyc;
        logic        stb;
    } wb_req_t;

    typedef struct packed {
        logic [31:0] dat;
        logic        ack;
    } wb_rsp_t;

    typedef enum logic {
        OUT_RELEASED,
        OUT_ASSERTED
    } out_state_t;

endpackage

// ==== hdl/event_filter.sv ====
// Purpose: filters a reset event level before it may pull the output low
// Assumes: event input synchronous to the clock
// Notes:   output goes high only after the event has stood a full filter time
`timescale 1ns/1ps
`default_nettype none
module event_filter
#(
    parameter int FILTER_CYCLES = 16
)
(
    input  wire logic i_sys_clk,
    input  wire logic i_reset_n,
    input  wire logic i_event,
    output var  logic o_filtered
);
    initial
    begin
        if (FILTER_CYCLES < 1)
            $error("filter needs at least one cycle");
    end

    typedef struct packed {
        logic [$clog2(FILTER_CYCLES+1)-1:0] cnt;
        logic                               out;
    } filt_state_t;

    filt_state_t state;
    filt_state_t next_state;

    // count while event stands, drop at once when it goes
    always_comb
    begin
        next_state = state;
        if (!i_event)
        begin
            next_state.cnt = '0;
            next_state.out = 1'b0;
        end
        else if (state.cnt == FILTER_CYCLES[$bits(state.cnt)-1:0] - 1'b1)
            next_state.out = 1'b1;
        else
            next_state.cnt = state.cnt + 1'b1;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
            state <= '0;
        else
            state <= next_state;
    end

    assign o_filtered = state.out;
endmodule
`default_nettype wire

// ==== hdl/reset_sequencer.sv ====
// Purpose: reset output generator with soft reset, wishbone register slave
// Assumes: supply-good, undervoltage and watchdog fail are synchronous levels
// Notes:   single-cycle ack; unmapped reads return zero, writes dropped
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rst_seq_params.svh"
module reset_sequencer
#(
    parameter int FILTER_CYCLES   = `FILTER_CYCLES,
    parameter int EXTENDED_CYCLES = `EXTENDED_DELAY_CYCLES,
    parameter int REDUCED_CYCLES  = `REDUCED_DELAY_CYCLES
)
(
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_reset_n,
    input  wire rst_seq_pkg::wb_req_t i_wb_req,
    output var  rst_seq_pkg::wb_rsp_t o_wb_rsp,
    input  wire logic                 i_supply_good,
    input  wire logic                 i_undervoltage,
    input  wire logic                 i_watchdog_fail,
    input  wire logic                 i_mode_normal,
    input  wire logic                 i_mode_stop,
    output var  logic                 o_reset_output_n,
    output var  logic [1:0]           o_uv_threshold,
    output var  logic                 o_soft_reset_pulse,
    output var  rst_seq_pkg::dev_mode_t o_mode
);
    import rst_seq_pkg::*;

    localparam int CW = $clog2(EXTENDED_CYCLES + 1);

    initial
    begin
        if (REDUCED_CYCLES < 1 || EXTENDED_CYCLES < REDUCED_CYCLES)
            $error("reset delays must be at least one cycle, reduced not above extended");
    end

    typedef struct packed {
        out_state_t  out;
        logic [CW-1:0] cnt;
        logic        use_ext;     // latched delay length for current hold
        logic        delay_sel;
        logic        soft_out_sel;
        logic [1:0]  thresh;
        logic [1:0]  mode_field;
        dev_mode_t   mode;
        logic        powered;     // first release already happened
        logic        soft_pulse;
        logic [31:0] rdat;
        logic        ack;
    } seq_state_t;

    seq_state_t state;
    seq_state_t next_state;
    logic       event_filt;
    logic       wb_write;
    logic       soft_cmd;
    logic       soft_ok;

    // watchdog fail merged with undervoltage before filtering
    event_filter #(
        .FILTER_CYCLES (FILTER_CYCLES)
    ) u_filter (
        .i_sys_clk  (i_sys_clk),
        .i_reset_n  (i_reset_n),
        .i_event    (i_undervoltage | i_watchdog_fail),
        .o_filtered (event_filt)
    );

    // delay length in cycles for the chosen setting
    function automatic logic [CW-1:0] delay_len(input logic ext);
        if (ext)
            delay_len = CW'(EXTENDED_CYCLES);
        else
            delay_len = CW'(REDUCED_CYCLES);
    endfunction

    // decode a write to one register word
    function automatic logic hit(input wb_req_t r, input logic [31:0] a);
        hit = r.cyc && r.stb && r.we && r.sel[0] && (r.adr == a);
    endfunction

    assign wb_write = i_wb_req.cyc && i_wb_req.stb && i_wb_req.we && !state.ack;
    // soft reset is the mode field written with 11
    assign soft_cmd = wb_write && hit(i_wb_req, `REG_MODE_CTRL)
                      && (i_wb_req.dat[`MODE_LSB +: 2] == `MODE_SOFT_RESET);
    // honoured only in normal or stop mode
    assign soft_ok  = soft_cmd && (i_mode_normal || i_mode_stop);

    always_comb
    begin
        next_state            = state;
        next_state.soft_pulse = 1'b0;
        next_state.ack        = 1'b0;
        next_state.rdat       = '0;

        // track the device mode as given by the mode inputs
        if (i_mode_normal)
            next_state.mode = MODE_NORMAL;
        else if (i_mode_stop)
            next_state.mode = MODE_STOP;
        else if (state.mode != MODE_INIT)
            next_state.mode = MODE_OTHER;

        // single-cycle wishbone answer, ack drops the cycle after
        if (i_wb_req.cyc && i_wb_req.stb && !state.ack)
        begin
            next_state.ack = 1'b1;
            if (!i_wb_req.we)
            begin
                if (i_wb_req.adr == `REG_MODE_CTRL)
                    next_state.rdat = {30'h0, state.mode_field};
                else if (i_wb_req.adr == `REG_RESET_CTRL)
                    next_state.rdat = {28'h0, state.thresh, state.soft_out_sel,
                                       state.delay_sel};
                else if (i_wb_req.adr == `REG_STATUS)
                    next_state.rdat = {28'h0, state.powered, state.mode,
                                       (state.out == OUT_ASSERTED)};
                else
                    next_state.rdat = '0;
            end
        end

        if (wb_write && hit(i_wb_req, `REG_MODE_CTRL) && !soft_cmd)
            next_state.mode_field = i_wb_req.dat[`MODE_LSB +: 2];
        if (wb_write && hit(i_wb_req, `REG_RESET_CTRL))
        begin
            next_state.delay_sel    = i_wb_req.dat[`DELAY_SEL_BIT];
            next_state.soft_out_sel = i_wb_req.dat[`SOFT_RST_OUT_SEL_BIT];
            next_state.thresh       = i_wb_req.dat[`THRESH_LSB +: 2];
        end

        // soft reset: init mode and both control registers back to default
        if (soft_ok)
        begin
            next_state.mode         = MODE_INIT;
            next_state.mode_field   = `MODE_RESET_VALUE;
            next_state.delay_sel    = 1'b0;
            next_state.soft_out_sel = 1'b0;
            next_state.thresh       = `THRESH_RESET_VALUE;
            next_state.soft_pulse   = 1'b1;
        end

        // output sequencing
        // hold low until supply first good, then extended delay
        if (!state.powered)
        begin
            next_state.out     = OUT_ASSERTED;
            next_state.use_ext = 1'b1;
            if (!i_supply_good)
                next_state.cnt = '0;
            else if (state.cnt == delay_len(1'b1) - 1'b1)
            begin
                next_state.out     = OUT_RELEASED;
                next_state.powered = 1'b1;
                next_state.cnt     = '0;
            end
            else
                next_state.cnt = state.cnt + 1'b1;
        end
        // any request restarts the delay, also while already low
        else if (event_filt || (soft_ok && !state.soft_out_sel))
        begin
            next_state.out = OUT_ASSERTED;
            next_state.cnt = '0;
            // soft reset always uses extended delay; else the select bit
            next_state.use_ext = (soft_ok && !state.soft_out_sel) ? 1'b1 : !state.delay_sel;
        end
        else if (state.out == OUT_ASSERTED)
        begin
            if (state.cnt == delay_len(state.use_ext) - 1'b1)
            begin
                next_state.out = OUT_RELEASED;
                next_state.cnt = '0;
            end
            else
                next_state.cnt = state.cnt + 1'b1;
        end
        // with output select set, soft reset touches registers only
    end

    // whole state registered in one place
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_reset_n)
        begin
            state      <= '0;
            state.out  <= OUT_ASSERTED;
            state.mode <= MODE_INIT;
        end
        else
            state <= next_state;
    end

    // outputs straight from flip-flops
    assign o_reset_output_n   = (state.out == OUT_RELEASED);
    assign o_uv_threshold     = state.thresh;
    assign o_soft_reset_pulse = state.soft_pulse;
    assign o_mode             = state.mode;
    assign o_wb_rsp.dat       = state.rdat;
    assign o_wb_rsp.ack       = state.ack;
endmodule
`default_nettype wire

// ==== bench/mcu_model.sv ====
// Purpose: controller side, reports the mode it has led the device into
// Assumes: a mode is only reported while reset is released
// Notes:   want 0 init, 1 normal, 2 stop
`timescale 1ns/1ps
`default_nettype none
module mcu_model
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset_output_n,
    input  wire logic [1:0] i_want,
    output var  logic       o_normal,
    output var  logic       o_stop
);
    always_ff @(posedge i_sys_clk)
    begin
        o_normal <= i_reset_output_n && (i_want == 2'h1);
        o_stop   <= i_reset_output_n && (i_want == 2'h2);
    end
endmodule
`default_nettype wire

// ==== bench/reset_sequencer_assertions.sv ====
// Purpose: port-level checks of the reset sequencer
// Assumes: one clock, sync active-low reset
// Notes:   soft reset pulse taken as the execution moment
`timescale 1ns/1ps
`default_nettype none
module reset_sequencer_assertions
(
    input wire logic                   i_sys_clk,
    input wire logic                   i_reset_n,
    input wire rst_seq_pkg::wb_req_t   i_wb_req,
    input wire rst_seq_pkg::wb_rsp_t   o_wb_rsp,
    input wire logic                   i_supply_good,
    input wire logic                   i_undervoltage,
    input wire logic                   i_watchdog_fail,
    input wire logic                   i_mode_normal,
    input wire logic                   i_mode_stop,
    input wire logic                   o_reset_output_n,
    input wire logic [1:0]             o_uv_threshold,
    input wire logic                   o_soft_reset_pulse,
    input wire rst_seq_pkg::dev_mode_t o_mode
);
    import rst_seq_pkg::*;
    logic ev;
    logic req;
    // merged event and a freshly taken bus request
    assign ev  = i_undervoltage | i_watchdog_fail;
    assign req = i_wb_req.cyc & i_wb_req.stb & ~o_wb_rsp.ack;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    sequence soft_cmd;
        req && i_wb_req.we && i_wb_req.adr == 32'h0 && i_wb_req.dat[1:0] == 2'h3;
    endsequence
    sequence bad_mode;
        !i_mode_normal && !i_mode_stop;
    endsequence
    a_ack_follows: assert property (req |=> o_wb_rsp.ack) else $error("no ack");
    a_ack_single: assert property (o_wb_rsp.ack |=> !o_wb_rsp.ack) else $error("long ack");
    a_fall_cause: assert property ($fell(o_reset_output_n) |-> $past(ev, 2)
        || o_soft_reset_pulse || $past(o_soft_reset_pulse)) else $error("bad fall");
    a_hold_event: assert property (ev && !o_reset_output_n |=> !o_reset_output_n)
        else $error("early release");
    a_release_gap: assert property ($rose(o_reset_output_n) |-> !$past(ev) && !$past(ev, 2))
        else $error("no delay");
    a_rise_supply: assert property ($rose(o_reset_output_n) |-> $past(i_supply_good))
        else $error("rise unpowered");
    a_soft_ignored: assert property (soft_cmd ##0 bad_mode |=> !o_soft_reset_pulse [*2])
        else $error("soft reset taken");
    a_pulse_single: assert property (o_soft_reset_pulse |=> !o_soft_reset_pulse)
        else $error("long pulse");
    a_soft_defaults: assert property (o_soft_reset_pulse |-> o_mode == MODE_INIT
        && o_uv_threshold == 2'h0) else $error("no defaults");
endmodule
bind reset_sequencer reset_sequencer_assertions u_chk (.i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n), .i_wb_req(i_wb_req), .o_wb_rsp(o_wb_rsp),
    .i_supply_good(i_supply_good), .i_undervoltage(i_undervoltage),
    .i_watchdog_fail(i_watchdog_fail), .i_mode_normal(i_mode_normal),
    .i_mode_stop(i_mode_stop), .o_reset_output_n(o_reset_output_n),
    .o_uv_threshold(o_uv_threshold), .o_soft_reset_pulse(o_soft_reset_pulse),
    .o_mode(o_mode));
`default_nettype wire

// ==== bench/reset_output_and_soft_reset_bench.sv ====
// Purpose: self-checking bench of the reset sequencer
// Assumes: shortened counts 4, 8, 2
// Notes:   delays checked with a small window
`timescale 1ns/1ps
`default_nettype none
module reset_output_and_soft_reset_bench;
    import rst_seq_pkg::*;
    localparam int FC = 4;
    localparam int EC = 8;
    localparam int RC = 2;
    logic i_sys_clk = 1'b0, i_reset_n = 1'b0, sg = 1'b0, uv = 1'b0, wd = 1'b0;
    logic nrm, stp, pulse, rn;
    logic [1:0] want = 2'h0, thr;
    wb_req_t req = '0;
    wb_rsp_t rsp;
    dev_mode_t md;
    integer seed = 32'h4958;
    int miscompares = 0, num_checks = 0, cyc = 0, n, p0, l0;
    int pulses = 0, lows = 0, lowrun = 0, lastlow = 0;
    logic [31:0] rd, v;
    always #2 i_sys_clk = ~i_sys_clk;
    reset_sequencer #(.FILTER_CYCLES(FC), .EXTENDED_CYCLES(EC), .REDUCED_CYCLES(RC)) u_dut (
        .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_wb_req(req), .o_wb_rsp(rsp),
        .i_supply_good(sg), .i_undervoltage(uv), .i_watchdog_fail(wd),
        .i_mode_normal(nrm), .i_mode_stop(stp), .o_reset_output_n(rn),
        .o_uv_threshold(thr), .o_soft_reset_pulse(pulse), .o_mode(md));
    mcu_model u_mcu (.i_sys_clk(i_sys_clk), .i_reset_output_n(rn), .i_want(want),
        .o_normal(nrm), .o_stop(stp));
    task automatic end_sim;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk_span(input string nm, input int lo, input int hi, input int g);
        num_checks++;
        if (g < lo || g > hi)
        begin
            miscompares++;
            $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
        end
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d);
        req <= '{adr:a, dat:d, sel:4'hf, we:we, cyc:1'b1, stb:1'b1};
        @(posedge i_sys_clk);
        while (rsp.ack !== 1'b1)
            @(posedge i_sys_clk);
        rd = rsp.dat;
        req <= '0;
        @(posedge i_sys_clk);
    endtask
    task automatic wait_out(input logic lvl, output int c);
        c = 0;
        while (rn !== lvl && c < 200)
        begin
            @(posedge i_sys_clk);
            c++;
        end
    endtask
    // tallies and timeout; the hang limit is far above the run length
    always @(posedge i_sys_clk)
    begin
        cyc <= cyc + 1;
        pulses <= pulses + (pulse === 1'b1);
        lows <= lows + (rn === 1'b0);
        lowrun <= (rn === 1'b0) ? lowrun + 1 : 0;
        if (rn === 1'b1 && lowrun != 0)
            lastlow <= lowrun;
        if (cyc == 20000)
        begin
            miscompares++;
            end_sim();
        end
    end
    initial
    begin
        repeat (16) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        repeat (20) @(posedge i_sys_clk);
        chk("out unpowered", 0, rn);
        sg <= 1'b1;
        wait_out(1'b1, n);
        chk_span("power-up delay", EC, EC + 3, n);
        wb(0, 32'h4, 0);
        chk("reset ctrl", 0, rd);
        wb(0, 32'hc, 0);
        chk("unmapped", 0, rd);
        uv <= 1'b1;
        repeat (FC - 1) @(posedge i_sys_clk);
        uv <= 1'b0;
        repeat (10) @(posedge i_sys_clk);
        chk("glitch", 1, rn);
        for (int k = 0; k < 2; k++)
        begin
            wb(1, 32'h4, k);
            if (k) wd <= 1'b1;
            else uv <= 1'b1;
            repeat (FC + 3 + {$random(seed)} % 8) @(posedge i_sys_clk);
            chk("low on event", 0, rn);
            uv <= 1'b0;
            wd <= 1'b0;
            wait_out(1'b1, n);
            chk_span("release delay", k ? RC : EC, (k ? RC : EC) + 3, n);
        end
        want <= 2'h1;
        v = {$random(seed)} % 3 + 1;
        wb(1, 32'h4, v << 2);
        chk("threshold", v, thr);
        for (int s = 0; s < 3; s++)
        begin
            want <= (s == 2) ? 2'h2 : 2'h1;
            wb(1, 32'h4, ((s == 1) ? 32'h2 : 32'h0) | (v << 2));
            repeat (4) @(posedge i_sys_clk);
            {p0, l0} = {pulses, lows};
            wb(1, 32'h0, 32'h3);
            wait_out(1'b1, n);
            repeat (EC + 6) @(posedge i_sys_clk);
            chk("pulse", p0 + 1, pulses);
            wb(0, 32'h4, 0);
            chk("defaults", 0, rd);
            if (s == 1) chk("no output", l0, lows);
            else chk_span("soft low", EC, EC + 1, lastlow);
        end
        want <= 2'h0;
        repeat (4) @(posedge i_sys_clk);
        p0 = pulses;
        wb(1, 32'h0, 32'h3);
        repeat (6) @(posedge i_sys_clk);
        chk("ignored", p0, pulses);
        end_sim();
    end
endmodule
`default_nettype wire
